// ===== eeprom_wp_regs.vh
// constants for the protected two-wire eeprom block
// assumes inclusion by bare name from the design files
`ifndef EEPROM_WP_REGS_VH
`define EEPROM_WP_REGS_VH
`define CTRL_MEMORY        4'h5 // arbitrary code for array access
`define CTRL_PROTECT       4'h6
`define PROT_TOP_ADDR      8'h7f
`define PAGE_BYTES         16
`define MEM_DEPTH          256
`define PROG_TIME_US       5000
`define CLK_MHZ            250
`define PROG_CYCLES        (`PROG_TIME_US * `CLK_MHZ)
`endif

// ===== byte_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an active high asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_r;
    reg [AW:0]      rd_ptr_r;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    assign empty     = (wr_ptr_r == rd_ptr_r);
    assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= {(AW+1){1'b0}};
            rd_ptr_r <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

    always @(posedge core_clk) begin
        if (push)
            mem[wr_ptr_r[AW-1:0]] <= in_data;
    end

    always @* begin
        out_data = mem[rd_ptr_r[AW-1:0]];
    end
endmodule // byte_fifo
`default_nettype wire

// ===== eeprom_write_protect_select.v
// two-wire eeprom slave with half-array software and full hardware protection
// assumes scl and sda are sampled by core_clk; pull-downs modelled as low defaults
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_wp_regs.vh"

// Operation
// - protect pin high blocks all writes; the protect command still sets the flag
// - protect low, flag clear: full access
// - floating protect pin reads as low
// - flag set blocks writes 00h-7fh only
// - flag set by command, never cleared; here rst clears it
// - hardware protect ignores flag state
// - respond only when select straps match
// - floating select straps read as low
// - sample on rising, launch after falling
// - data line pulled low or released
// - array of 256 bytes by 8 bits
// - page writes up to 16 bytes
// - self-timed programming within 5 ms
// - host can probe flag via acknowledge
// - control code selects memory or protect
// - no acknowledge for protect code once set
// - protected writes acknowledged, not stored
module eeprom_write_protect_select #(
    parameter PROG_CYCLES = `PROG_CYCLES
) (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       scl,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    input  wire       write_protect,
    input  wire       select_strap_bit2,
    input  wire       select_strap_bit1,
    input  wire       select_strap_bit0,
    output wire       soft_protect_set,
    output wire       programming_busy
);
    // ****************************************
    // states
    // ****************************************
    localparam S_IDLE = 3'd0;
    localparam S_DEV  = 3'd1;
    localparam S_WADR = 3'd2;
    localparam S_WDAT = 3'd3;
    localparam S_RDAT = 3'd4;
    localparam S_RACK = 3'd5;
    localparam S_ACK  = 3'd6;
    localparam S_PROG = 3'd7;

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg [1:0] scl_s_r;
    reg [1:0] sda_s_r;
    reg [1:0] wp_s_r;
    reg [1:0] strap2_s_r;
    reg [1:0] strap1_s_r;
    reg [1:0] strap0_s_r;
    reg       scl_d_r;
    reg       sda_d_r;

    // an unknown or floating pin resolves to low, as the internal pull-down would
    function pull_low;
        input v;
        begin
            pull_low = (v === 1'b1);
        end
    endfunction

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_s_r <= 2'b11;
            sda_s_r <= 2'b11;
            wp_s_r  <= 2'b00;
            strap2_s_r <= 2'b00;
            strap1_s_r <= 2'b00;
            strap0_s_r <= 2'b00;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], scl};
            sda_s_r <= {sda_s_r[0], sda_in};
            wp_s_r  <= {wp_s_r[0], pull_low(write_protect)};
            // straps are static, but still synchronised like any pin
            strap2_s_r <= {strap2_s_r[0], pull_low(select_strap_bit2)};
            strap1_s_r <= {strap1_s_r[0], pull_low(select_strap_bit1)};
            strap0_s_r <= {strap0_s_r[0], pull_low(select_strap_bit0)};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end

    wire scl_rise = scl_s_r[1] && !scl_d_r;
    wire scl_fall = !scl_s_r[1] && scl_d_r;
    wire start_c  = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
    wire stop_c   = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];
    wire [2:0] straps = {strap2_s_r[1], strap1_s_r[1], strap0_s_r[1]};

    // ****************************************
    // state
    // ****************************************
    reg [7:0]  mem [0:`MEM_DEPTH-1];
    reg [2:0]  state_r;
    reg [2:0]  after_ack_r;
    reg [7:0]  shift_r;
    reg [3:0]  bit_cnt_r;
    reg [7:0]  addr_r;
    reg        flag_r;
    reg        prot_cmd_r;
    reg        ack_pend_r;
    reg        rd_ack_r;
    reg [31:0] prog_cnt_r;
    reg        wrote_r;
    reg [4:0]  page_cnt_r;

    assign soft_protect_set = flag_r;
    assign programming_busy = (state_r == S_PROG);

    // per-byte decision: hardware pin first, then the lower half under the flag
    function byte_blocked;
        input       wp;
        input       flag;
        input [7:0] a;
        begin
            byte_blocked = wp || (flag && (a <= `PROT_TOP_ADDR));
        end
    endfunction

    // ****************************************
    // program staging fifo
    // ****************************************
    wire [15:0] fifo_out;
    wire        fifo_valid;
    wire        fifo_in_ready;
    wire        push_byte;
    reg         fifo_pop;

    byte_fifo #(.WIDTH(16), .DEPTH(4), .AW(2)) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_data   ({addr_r, rx}),
        .in_valid  (push_byte),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // array write port drains the fifo one byte per clock
    // a byte arrives every nine scl periods, so the fifo never fills in practice
    always @* begin
        fifo_pop = fifo_valid;
    end

    always @(posedge core_clk) begin
        if (fifo_valid)
            mem[fifo_out[15:8]] <= fifo_out[7:0];
    end

    wire byte_done  = scl_rise && (bit_cnt_r == 4'd7);
    wire sda_bit    = sda_s_r[1];
    wire [7:0] rx   = {shift_r[6:0], sda_bit};
    assign push_byte = (state_r == S_WDAT) && byte_done && !prot_cmd_r
                       && !byte_blocked(wp_s_r[1], flag_r, addr_r)
                       && (page_cnt_r < `PAGE_BYTES)
                       && fifo_in_ready;
    wire dev_match  = (rx[3:1] == straps);
    wire code_mem   = (rx[7:4] == `CTRL_MEMORY);
    wire code_prot  = (rx[7:4] == `CTRL_PROTECT) && !flag_r;

    // ****************************************
    // protocol engine
    // ****************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r     <= S_IDLE;
            after_ack_r <= S_IDLE;
            shift_r     <= 8'h00;
            bit_cnt_r   <= 4'h0;
            addr_r      <= 8'h00;
            flag_r      <= 1'b0;
            prot_cmd_r  <= 1'b0;
            ack_pend_r  <= 1'b0;
            rd_ack_r    <= 1'b0;
            prog_cnt_r  <= 32'h0000_0000;
            wrote_r     <= 1'b0;
            page_cnt_r  <= 5'h00;
            sda_out     <= 1'b0;
            sda_oe      <= 1'b0;
        end else if (state_r == S_PROG) begin
            // inputs ignored while programming
            sda_oe <= 1'b0;
            if (prog_cnt_r >= PROG_CYCLES - 1)
                state_r <= S_IDLE;
            else
                prog_cnt_r <= prog_cnt_r + 32'h0000_0001;
        end else if (stop_c) begin
            sda_oe <= 1'b0;
            if (wrote_r) begin
                state_r    <= S_PROG;
                prog_cnt_r <= 32'h0000_0000;
                if (prot_cmd_r)
                    flag_r <= 1'b1;
            end else begin
                state_r <= S_IDLE;
            end
            wrote_r <= 1'b0;
        end else if (start_c) begin
            state_r    <= S_DEV;
            bit_cnt_r  <= 4'h0;
            sda_oe     <= 1'b0;
            page_cnt_r <= 5'h00;
        end else begin
            case (state_r)
            S_DEV, S_WADR, S_WDAT: begin
                if (scl_rise) begin
                    shift_r   <= rx;
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                if (byte_done) begin
                    bit_cnt_r  <= 4'h0;
                    ack_pend_r <= 1'b1;
                    if (state_r == S_DEV) begin
                        if (dev_match && (code_mem || code_prot)) begin
                            prot_cmd_r  <= code_prot;
                            after_ack_r <= rx[0] ? S_RDAT : S_WADR;
                        end else begin
                            ack_pend_r  <= 1'b0;
                            after_ack_r <= S_IDLE;
                        end
                    end else if (state_r == S_WADR) begin
                        addr_r      <= rx;
                        after_ack_r <= S_WDAT;
                        wrote_r     <= prot_cmd_r;
                    end else begin
                        // protected bytes still take the acknowledge
                        wrote_r     <= 1'b1;
                        after_ack_r <= S_WDAT;
                        if (page_cnt_r < `PAGE_BYTES)
                            page_cnt_r <= page_cnt_r + 5'h01;
                        // refused bytes still advance, so each byte is judged at its own address
                        addr_r <= {addr_r[7:4], addr_r[3:0] + 4'h1};
                    end
                    state_r <= S_ACK;
                end
            end
            S_ACK: begin
                if (scl_fall && ack_pend_r) begin
                    sda_out    <= 1'b0;
                    sda_oe     <= 1'b1;
                    ack_pend_r <= 1'b0;
                end else if (scl_fall) begin
                    sda_oe  <= 1'b0;
                    state_r <= after_ack_r;
                    if (after_ack_r == S_RDAT) begin
                        sda_out <= 1'b0;
                        sda_oe  <= !mem[addr_r][7];
                        shift_r <= mem[addr_r];
                    end
                end
            end
            S_RDAT: begin
                if (scl_fall) begin
                    if (bit_cnt_r == 4'd7) begin
                        sda_oe    <= 1'b0;
                        state_r   <= S_RACK;
                        bit_cnt_r <= 4'h0;
                        addr_r    <= addr_r + 8'h01;
                    end else begin
                        sda_oe    <= !shift_r[6];
                        shift_r   <= {shift_r[6:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
            end
            S_RACK: begin
                // host acknowledge decides whether another byte follows
                if (scl_rise)
                    rd_ack_r <= !sda_bit;
                if (scl_fall) begin
                    if (rd_ack_r) begin
                        state_r <= S_RDAT;
                        shift_r <= mem[addr_r];
                        sda_oe  <= !mem[addr_r][7];
                    end else begin
                        state_r <= S_IDLE;
                    end
                end
            end
            default: begin
                sda_oe <= 1'b0;
            end
            endcase
        end
    end
    // a protect-code address byte is acknowledged only while the flag is clear
endmodule // eeprom_write_protect_select
`default_nettype wire

// ===== eeprom_wp_chk.sv
// port checker for the protected two-wire eeprom block
// assumes binding onto the design top, one core_clk domain
`timescale 1ns/100ps
`default_nettype none
module eeprom_wp_chk #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic soft_protect_set,
    input wire logic programming_busy
);
// ********************
// assertions
// ********************
logic [31:0] busy_cnt_r;
always_ff @(posedge core_clk or posedge rst) begin
    if (rst) busy_cnt_r <= '0;
    else busy_cnt_r <= programming_busy ? busy_cnt_r + 32'h0000_0001 : '0;
end
default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);
// stop level: both lines high
sequence stop_seen;
    scl && sda_in;
endsequence
AST_PULL_ONLY: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
AST_FLAG_KEEP: assert property (soft_protect_set |=> soft_protect_set)
    else $error("protect flag cleared");
AST_FLAG_AT_STOP: assert property ($rose(soft_protect_set) |-> stop_seen)
    else $error("protect flag set outside stop");
AST_BUSY_AT_STOP: assert property ($rose(programming_busy) |-> stop_seen)
    else $error("programming began outside stop");
AST_BUSY_LEN: assert property (programming_busy |-> busy_cnt_r < PROG_CYCLES)
    else $error("programming time too long");
AST_BUSY_EXACT: assert property ($fell(programming_busy) |-> busy_cnt_r == PROG_CYCLES)
    else $error("programming time not the set length");
AST_BUSY_QUIET: assert property (programming_busy |-> !sda_oe)
    else $error("bus answered while programming");
AST_LAUNCH_LOW: assert property ($changed(sda_oe) |-> !scl)
    else $error("data launched while clock high");
AST_HOLD_HIGH: assert property ($rose(scl) |=> $stable(sda_oe) [*4])
    else $error("data moved after clock rise");
endmodule // eeprom_wp_chk
bind eeprom_write_protect_select eeprom_wp_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .core_clk(core_clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .soft_protect_set(soft_protect_set),
    .programming_busy(programming_busy));
`default_nettype wire

// ===== two_wire_host.sv
// bus host model: open-drain data, clock of 12 core cycles
// assumes an external pull-up forms the data wire
`timescale 1ns/100ps
`default_nettype none
module two_wire_host (
    input  wire logic core_clk,
    input  wire logic sda_w,
    output var  logic scl,
    output var  logic pull
);
// ********************
// bit level
// ********************
initial begin
    scl = 1'b1;
    pull = 1'b0;
end
task automatic w(input int n);
    repeat (n) @(posedge core_clk);
endtask
// data moves only mid-low, sampled late in high
task automatic clk_bit(input logic pl, output logic r);
    scl <= 1'b0;
    w(3);
    pull <= pl;
    w(3);
    scl <= 1'b1;
    w(5);
    r = sda_w;
    w(1);
endtask
task automatic start_cond();
    logic r;
    clk_bit(1'b0, r);
    pull <= 1'b1;
    w(6);
endtask
task automatic stop_cond();
    logic r;
    clk_bit(1'b1, r);
    pull <= 1'b0;
    w(6);
endtask
task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(!d[i], r);
    clk_bit(1'b0, r);
    ack = !r;
endtask
// last byte is not acknowledged, which ends the read
task automatic read_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
        clk_bit(1'b0, r);
        d[i] = r;
    end
    clk_bit(!last, r);
endtask
endmodule // two_wire_host
`default_nettype wire

// ===== eeprom_write_protect_select_test.sv
// self-checking bench for the protected two-wire eeprom block
// assumes the host model drives the bus, core_clk at 250 mhz
`timescale 1ns/100ps
`default_nettype none
module eeprom_write_protect_select_test;
// ********************
// bench
// ********************
localparam logic [6:0] MEM = 7'h2d;
localparam logic [6:0] PRT = 7'h35;
logic       core_clk = 1'b0;
logic       rst      = 1'b1;
logic       wp       = 1'b0;
logic [2:0] strap    = 3'b101;
int         bad_count = 0;
int         n_tests   = 0;
wire        scl, pull, sda_out, sda_oe, flag, busy;
wire        sda_w = !(pull | sda_oe);
always #2 core_clk = ~core_clk;
eeprom_write_protect_select #(.PROG_CYCLES(200)) uut (
    .core_clk(core_clk), .rst(rst), .scl(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(wp),
    .select_strap_bit2(strap[2]), .select_strap_bit1(strap[1]),
    .select_strap_bit0(strap[0]), .soft_protect_set(flag), .programming_busy(busy));
two_wire_host h (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .pull(pull));
task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
        bad_count++;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
endtask
// even writes refused by protection leave the part busy, so always wait it out
task automatic wait_idle();
    h.w(8);
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) h.w(1);
    chk({7'h00, busy}, 8'h00);
    if (busy !== 1'b0) give_verdict();
endtask
task automatic xfer(input logic [6:0] hi, input logic [7:0] a, input logic [7:0] d,
                    input int n, input logic ack_exp);
    logic ack;
    h.start_cond();
    h.send_byte({hi, 1'b0}, ack);
    chk({7'h00, ack}, {7'h00, ack_exp});
    if (ack) begin
        h.send_byte(a, ack);
        for (int i = 0; i < n; i++) h.send_byte(d + i[7:0], ack);
    end
    h.stop_cond();
    chk({7'h00, busy}, {7'h00, ack_exp});
    wait_idle();
endtask
task automatic rd(input logic [6:0] hi, input logic [7:0] a, input logic [7:0] exp);
    logic ack;
    logic [7:0] q;
    h.start_cond();
    h.send_byte({hi, 1'b0}, ack);
    h.send_byte(a, ack);
    h.start_cond();
    h.send_byte({hi, 1'b1}, ack);
    h.read_byte(1'b1, q);
    h.stop_cond();
    chk(q, exp);
endtask
task automatic sc_open();
    xfer(MEM, 8'h10, 8'h3c, 3, 1'b1);
    for (int i = 0; i < 3; i++) rd(MEM, 8'h10 + i[7:0], 8'h3c + i[7:0]);
    xfer(MEM, 8'h7f, 8'h11, 1, 1'b1);
    xfer(MEM, 8'h80, 8'h22, 1, 1'b1);
    rd(MEM, 8'h7f, 8'h11);
    xfer(MEM, 8'ha8, 8'h00, 17, 1'b1);
    rd(MEM, 8'ha0, 8'h08);
    rd(MEM, 8'ha8, 8'h00);
endtask
task automatic sc_float();
    strap <= 3'bzzz;
    wp <= 1'bz;
    xfer(7'h28, 8'h20, 8'h5a, 1, 1'b1);
    rd(7'h28, 8'h20, 8'h5a);
    strap <= 3'b101;
    wp <= 1'b0;
endtask
task automatic sc_strap();
    xfer(7'h2c, 8'h10, 8'h00, 1, 1'b0);
    rd(MEM, 8'h10, 8'h3c);
endtask
task automatic sc_hw();
    wp <= 1'b1;
    xfer(MEM, 8'h80, 8'h99, 1, 1'b1);
    rd(MEM, 8'h80, 8'h22);
    wp <= 1'b0;
endtask
task automatic sc_soft();
    xfer(PRT, 8'h00, 8'h00, 1, 1'b1);
    chk({7'h00, flag}, 8'h01);
    xfer(PRT, 8'h00, 8'h00, 1, 1'b0);
    xfer(MEM, 8'h7f, 8'h33, 1, 1'b1);
    rd(MEM, 8'h7f, 8'h11);
    xfer(MEM, 8'h80, 8'h44, 1, 1'b1);
    rd(MEM, 8'h80, 8'h44);
endtask
task automatic sc_both();
    wp <= 1'b1;
    xfer(MEM, 8'h80, 8'h55, 1, 1'b1);
    rd(MEM, 8'h80, 8'h44);
    chk({7'h00, flag}, 8'h01);
    wp <= 1'b0;
endtask
initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    h.w(4);
    sc_open();
    sc_float();
    sc_strap();
    sc_hw();
    sc_soft();
    sc_both();
    give_verdict();
end
endmodule // eeprom_write_protect_select_test
`default_nettype wire
